// >>> design/tac_pkg.sv
package tac_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0C;
  localparam logic [7:0] OFF_SOFTRST = 8'h10;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_DETECT_ONLY = 0;
  localparam int CTRL_FIVE = 1;
  localparam int CTRL_FILT = 2;
  localparam int CTRL_XSEL = 4;
  localparam int CTRL_YSEL = 7;
  localparam int CTRL_SETTLE = 10;
  localparam int CTRL_DETRES = 14;
  localparam int CTRL_W = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------
  // status and result fields
  // ----------------------------------------
  localparam int STAT_PEN = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_VALID = 2;
  localparam int RES_AXIS = 12;
  localparam logic [7:0] SOFT_RESET_CODE = 8'hDE;

  // ----------------------------------------
  // bias switch indices
  // ----------------------------------------
  localparam int SW_X_LEFT = 0;
  localparam int SW_X_RIGHT = 1;
  localparam int SW_Y_TOP = 2;
  localparam int SW_Y_BOTTOM = 3;
  localparam int SW_CORNER_DET = 4;
  localparam int SW_WIPER_GND = 5;
  localparam int SW_WIPER_ADC = 6;
  localparam int SW_N = 7;

  // ----------------------------------------
  // filter and timing
  // ----------------------------------------
  localparam int K_NUM = 4079;
  localparam int FULL_SCALE = 4095;
  localparam int MAX_SAMPLES = 7;
  localparam int CLK_MHZ = 10;
  localparam int POWERUP_NS = 2000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_STEP_NS = 1000;
  localparam int SETTLE_STEP_CYC = (SETTLE_STEP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV = 3'b011,
    ST_CALC = 3'b100
  } tac_state_e;
endpackage

// >>> design/tac_core.sv
`timescale 1ns/1ns
// Overview of operation
// [R01] host picks each 3-bit panel resistor code from panel resistance, 111 above 18780.
// [R02] five-wire X pairs the left and the right corners; Y pairs top and bottom corners.
// [R03] five-wire conversion routes the wiper electrode to the converter input.
// [R04] position results are 12-bit codes, full scale 4095.
// [R05] pen detection biases bottom-right corner via detect resistor and grounds the wiper.
// [R06] a voltage drop on the bottom-right corner sets the pen touch flag.
// [R07] host should choose the 200 kOhm detect resistor setting.
// [R08] host should raise settling delay for high-resistance panels.
// [R09] in detect-only mode a touch pulls the interrupt line low.
// [R10] filter selector gives 1, 3, 5 or 7 samples.
// [R11] averaged outputs are scaled by 4079/4095 after the mean.
// [R12] setting 3 sorts seven samples and averages the middle three.
// [R13] each processed result is 12 bits, readable by the host.
// [R14] during power-up reset the interrupt line is held low.
// [R15] bus transfers are ignored until power-up reset completes.
// [R16] after power-up the core is in manual mode, acquisition idle.
// [R17] writing 0xDE to the software reset register resets everything; the code leaves the sample store and the bus output registers untouched.
// [R18] reset pin low holds interrupt low; released after reset ends.
// [R19] reading status clears the pen flag and releases the interrupt.
// [R20] sample history restarts on every conversion.
// [R21] any other software reset value has no effect.
module tac_core #(
  parameter int POWERUP_CYCLES = tac_pkg::POWERUP_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic reset_in_n,
  input wire logic br_drop,
  output logic irq_out_n_o,
  output logic irq_out_n_oe,
  // analog front end
  output logic [tac_pkg::SW_N-1:0] bias_sw,
  output logic [2:0] x_panel_resistor_select,
  output logic [2:0] y_panel_resistor_select,
  output logic [1:0] touch_detect_resistor,
  output logic adc_start,
  input wire logic adc_valid,
  input wire logic [11:0] adc_data
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sy1_q;
  logic [1:0] sy2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_q <= 2'h1;
      sy2_q <= 2'h1;
    end else if (ce) begin
      sy1_q <= {br_drop, reset_in_n};
      sy2_q <= sy1_q;
    end
  end
  wire pin_rst = ~sy2_q[0];
  wire drop_s = sy2_q[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  tac_pkg::tac_state_e state_q, state_d;
  logic [15:0] ctrl_q;
  logic [15:0] cnt_q;
  logic [2:0] idx_q;
  logic axis_q;
  logic pen_q;
  logic valid_q;
  logic [11:0] res_q;
  logic [11:0] smp_q [tac_pkg::MAX_SAMPLES];
  logic rd_pen_q;

  wire detect_only = ctrl_q[tac_pkg::CTRL_DETECT_ONLY];
  wire five = ctrl_q[tac_pkg::CTRL_FIVE];
  wire [1:0] filt = ctrl_q[tac_pkg::CTRL_FILT +: 2];
  wire [3:0] settle = ctrl_q[tac_pkg::CTRL_SETTLE +: 4];
  wire in_init = (state_q == tac_pkg::ST_INIT);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = psel & ~penable & ~pready;
  wire access = psel & penable & pready & ~in_init; // [R15]
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire wr_ctrl = wr & (paddr == tac_pkg::OFF_CTRL);
  wire wr_cmd = wr & (paddr == tac_pkg::OFF_CMD);
  wire soft_rst = wr & (paddr == tac_pkg::OFF_SOFTRST)
    & (pwdata[7:0] == tac_pkg::SOFT_RESET_CODE); // [R17] [R21]
  wire rd_stat = rd & (paddr == tac_pkg::OFF_STATUS);
  // pin and software reset share one synchronous clear path
  wire clear = pin_rst | soft_rst; // [R18] [R17]
  wire mapped = (paddr == tac_pkg::OFF_CTRL) | (paddr == tac_pkg::OFF_STATUS)
    | (paddr == tac_pkg::OFF_CMD) | (paddr == tac_pkg::OFF_RESULT)
    | (paddr == tac_pkg::OFF_SOFTRST);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (!in_init) begin
      unique case (paddr)
        tac_pkg::OFF_CTRL: rdata[15:0] = ctrl_q;
        tac_pkg::OFF_STATUS: rdata[2:0] = {valid_q, ~(state_q == tac_pkg::ST_IDLE), pen_q};
        tac_pkg::OFF_RESULT: rdata[12:0] = {axis_q, res_q}; // [R13]
        default: rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // filter
  // ----------------------------------------
  logic [12*tac_pkg::MAX_SAMPLES-1:0] smp_flat;
  genvar g;
  generate
    for (g = 0; g < tac_pkg::MAX_SAMPLES; g++) begin : g_flat
      assign smp_flat[12*g +: 12] = smp_q[g];
    end
  endgenerate

  // sum of the three centre values; ties are broken by index so ranks are unique
  function automatic int unsigned mid3_sum(input logic [12*tac_pkg::MAX_SAMPLES-1:0] s);
    int unsigned acc;
    int unsigned rank;
    acc = 0;
    for (int i = 0; i < tac_pkg::MAX_SAMPLES; i++) begin
      rank = 0;
      for (int j = 0; j < tac_pkg::MAX_SAMPLES; j++) begin
        if ((s[12*j +: 12] < s[12*i +: 12]) || ((s[12*j +: 12] == s[12*i +: 12]) && (j < i)))
          rank = rank + 1;
      end
      if (rank >= 2 && rank <= 4)
        acc = acc + 32'(s[12*i +: 12]);
    end
    return acc;
  endfunction

  function automatic int unsigned first_sum(input logic [12*tac_pkg::MAX_SAMPLES-1:0] s,
                                            input int unsigned n);
    int unsigned acc;
    acc = 0;
    for (int i = 0; i < tac_pkg::MAX_SAMPLES; i++) begin
      if (i < n)
        acc = acc + 32'(s[12*i +: 12]);
    end
    return acc;
  endfunction

  logic [2:0] nsamp;
  int unsigned fsum;
  int unsigned fdiv;
  always_comb begin
    unique case (filt) // [R10]
      2'd0: nsamp = 3'd1;
      2'd1: nsamp = 3'd3;
      2'd2: nsamp = 3'd5;
      2'd3: nsamp = 3'd7;
    endcase
    fsum = (filt == 2'd3) ? mid3_sum(smp_flat) : first_sum(smp_flat, 32'(nsamp)); // [R12]
    fdiv = (filt == 2'd3) ? 3 : 32'(nsamp);
  end
  // mean then k scaling; one-sample mode passes the code untouched
  wire [11:0] filt_out = (filt == 2'd0) ? smp_q[0] :
    12'((fsum * tac_pkg::K_NUM) / (fdiv * tac_pkg::FULL_SCALE)); // [R11] [R04]

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire [15:0] settle_cyc = 16'(settle * tac_pkg::SETTLE_STEP_CYC);
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tac_pkg::ST_INIT: if (cnt_q >= 16'(POWERUP_CYCLES)) state_d = tac_pkg::ST_IDLE;
      tac_pkg::ST_IDLE: if (wr_cmd) state_d = tac_pkg::ST_SETTLE;
      tac_pkg::ST_SETTLE: if (cnt_q >= settle_cyc) state_d = tac_pkg::ST_CONV;
      tac_pkg::ST_CONV: if (adc_valid && (idx_q + 3'd1 == nsamp)) state_d = tac_pkg::ST_CALC;
      tac_pkg::ST_CALC: state_d = tac_pkg::ST_IDLE;
      default: state_d = tac_pkg::ST_INIT;
    endcase
  end

  logic [tac_pkg::SW_N-1:0] sw_d;
  always_comb begin
    sw_d = '0;
    if (state_q == tac_pkg::ST_IDLE && detect_only) begin
      sw_d[tac_pkg::SW_CORNER_DET] = 1'b1; // [R05]
      sw_d[tac_pkg::SW_WIPER_GND] = 1'b1; // [R05]
    end else if ((state_q == tac_pkg::ST_SETTLE || state_q == tac_pkg::ST_CONV) && five) begin
      sw_d[tac_pkg::SW_X_LEFT] = ~axis_q; // [R02]
      sw_d[tac_pkg::SW_X_RIGHT] = ~axis_q; // [R02]
      sw_d[tac_pkg::SW_Y_TOP] = axis_q; // [R02]
      sw_d[tac_pkg::SW_Y_BOTTOM] = axis_q; // [R02]
      sw_d[tac_pkg::SW_WIPER_ADC] = 1'b1; // [R03]
    end
  end

  // ----------------------------------------
  // pen flag
  // ----------------------------------------
  // hardware set beats the read clear; only a flag already shown to the host is cleared
  wire pen_set = detect_only & (state_q == tac_pkg::ST_IDLE) & drop_s; // [R06]
  wire pen_d = pen_set | (pen_q & ~(rd_stat & rd_pen_q)); // [R19]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tac_pkg::ST_INIT;
      ctrl_q <= tac_pkg::CTRL_RESET;
      cnt_q <= 16'h0000;
      idx_q <= 3'h0;
      axis_q <= 1'b0;
      pen_q <= 1'b0;
      valid_q <= 1'b0;
      res_q <= 12'h000;
    end else if (ce) begin
      if (clear) begin
        state_q <= tac_pkg::ST_INIT;
        ctrl_q <= tac_pkg::CTRL_RESET; // [R16]
        cnt_q <= 16'h0000;
        idx_q <= 3'h0;
        axis_q <= 1'b0;
        pen_q <= 1'b0;
        valid_q <= 1'b0;
        res_q <= 12'h000;
      end else begin
        state_q <= state_d;
        cnt_q <= (state_d != state_q) ? 16'h0000 : cnt_q + 16'h0001;
        pen_q <= pen_d;
        if (wr_ctrl)
          ctrl_q <= pwdata[15:0];
        if (state_q == tac_pkg::ST_IDLE && wr_cmd) begin
          axis_q <= pwdata[0];
          idx_q <= 3'h0; // [R20]
          valid_q <= 1'b0;
        end
        if (state_q == tac_pkg::ST_CONV && adc_valid)
          idx_q <= idx_q + 3'd1;
        if (state_q == tac_pkg::ST_CALC) begin
          res_q <= filt_out;
          valid_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // sample store
  // ----------------------------------------
  // sample store has no reset; only entries of the current conversion are read
  always_ff @(posedge pclk) begin
    if (ce && state_q == tac_pkg::ST_CONV && adc_valid)
      smp_q[idx_q] <= adc_data;
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_pen_q <= 1'b0;
      irq_out_n_oe <= 1'b1;
      irq_out_n_o <= 1'b0;
      bias_sw <= '0;
      adc_start <= 1'b0;
      x_panel_resistor_select <= 3'h0;
      y_panel_resistor_select <= 3'h0;
      touch_detect_resistor <= 2'h0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata <= rdata;
        rd_pen_q <= rdata[tac_pkg::STAT_PEN] & (paddr == tac_pkg::OFF_STATUS);
        pslverr <= ~mapped & ~in_init;
      end
      // interrupt low through reset and power-up, and on a touch in detect-only mode
      irq_out_n_oe <= clear | (state_d == tac_pkg::ST_INIT) // [R14] [R18]
        | (detect_only & pen_d); // [R09]
      // open-drain data stays low; only the enable moves the line
      irq_out_n_o <= 1'b0;
      bias_sw <= clear ? '0 : sw_d;
      // request stays up through the whole conversion; a gap would restart the sample count
      adc_start <= ~clear & (state_d == tac_pkg::ST_CONV);
      x_panel_resistor_select <= ctrl_q[tac_pkg::CTRL_XSEL +: 3]; // [R01]
      y_panel_resistor_select <= ctrl_q[tac_pkg::CTRL_YSEL +: 3]; // [R01]
      touch_detect_resistor <= ctrl_q[tac_pkg::CTRL_DETRES +: 2]; // [R07]
    end
  end
endmodule

// >>> sim/tac_core_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module tac_core_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // pins and front end
  input wire logic reset_in_n,
  input wire logic br_drop,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe,
  input wire logic [tac_pkg::SW_N-1:0] bias_sw,
  input wire logic adc_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_INIT_IRQ: assert property ($rose(presetn) |-> irq_out_n_oe)
    else $error("irq line not held after reset");
  AST_INIT_READ: assert property (pready && !pwrite && irq_out_n_oe && bias_sw == 0 |-> prdata == 0)
    else $error("read returned data before power-up done");
  AST_IDLE_AFTER: assert property ($fell(irq_out_n_oe) && !bias_sw[5] |-> bias_sw == 0 && !adc_start)
    else $error("acquisition active after power-up");
  AST_TIE: assert property (|bias_sw[3:0] |-> bias_sw[3:0] inside {4'b0011, 4'b1100})
    else $error("corner pairing wrong");
  AST_WIPER_ADC: assert property (bias_sw[0] || bias_sw[2] |-> bias_sw[6] && !bias_sw[5])
    else $error("wiper not routed to converter");
  AST_DETECT_BIAS: assert property (bias_sw[4] |-> bias_sw[5] && !bias_sw[6])
    else $error("detect bias wrong");
  AST_PEN_IRQ: assert property ((bias_sw[4] && br_drop) [*3] |-> ##[1:4] irq_out_n_oe)
    else $error("touch did not pull irq");
  AST_PIN_RESET: assert property (!reset_in_n [*5] |-> irq_out_n_oe && !irq_out_n_o)
    else $error("irq not low during pin reset");
  AST_APB_ONE: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access not answered in one cycle");
  AST_RES_WIDTH: assert property (pready && !pwrite && paddr == 8'h0C |-> prdata[31:13] == 0)
    else $error("result wider than 12 bits");
endmodule
bind tac_core tac_core_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .reset_in_n, .br_drop, .irq_out_n_o, .irq_out_n_oe, .bias_sw, .adc_start);

// >>> sim/tac_afe_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// converter stand-in
// ----------------------------------------
module tac_afe_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // converter handshake
  input wire logic adc_start,
  output logic adc_valid,
  output logic [11:0] adc_data
);
  logic [2:0] idx_q;
  logic [1:0] gap_q;
  // sample sequence restarts per request; data toggles between pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 3'h0;
      gap_q <= 2'h0;
      adc_valid <= 1'b0;
      adc_data <= 12'h000;
    end else if (adc_start && gap_q == 2'h2) begin
      adc_valid <= 1'b1;
      adc_data <= 12'((int'(idx_q) * 1237 + 333) % 4096);
      idx_q <= idx_q + 3'h1;
      gap_q <= 2'h0;
    end else begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      gap_q <= adc_start ? gap_q + 2'h1 : 2'h0;
      idx_q <= adc_start ? idx_q : 3'h0;
    end
  end
endmodule

// >>> sim/touch_acquisition_core_tb.sv
`timescale 1ns/1ns
module touch_acquisition_core_tb;
  logic pclk, presetn, psel, penable, pwrite, reset_in_n, br_drop, err;
  logic pready, pslverr, irq_out_n_o, irq_out_n_oe, adc_start, adc_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] bias_sw;
  logic [11:0] adc_data;
  logic [2:0] x_sel, y_sel;
  logic [1:0] det_res;
  int num_errors, checks, cyc;

  tac_core #(.POWERUP_CYCLES(4)) uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_in_n, .br_drop, .irq_out_n_o,
    .irq_out_n_oe, .bias_sw, .x_panel_resistor_select(x_sel), .y_panel_resistor_select(y_sel),
    .touch_detect_resistor(det_res), .adc_start, .adc_valid, .adc_data);
  tac_afe_model afe (.pclk, .presetn, .adc_start, .adc_valid, .adc_data);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task wrap_up;
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; if it never comes, only the bench timeout does
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_ready;
    while (irq_out_n_oe !== 1'b0) @(posedge pclk);
  endtask
  function int expv(int f);
    int s[7];
    int t, n, sum;
    n = 2 * f + 1;
    sum = 0;
    for (int i = 0; i < 7; i++) s[i] = (i * 1237 + 333) % 4096;
    if (f == 0) return s[0];
    if (f == 3) begin
      for (int i = 0; i < 7; i++) for (int j = 0; j < 6; j++) if (s[j] > s[j+1]) begin
        t = s[j];
        s[j] = s[j+1];
        s[j+1] = t;
      end
      return (s[2] + s[3] + s[4]) * 4079 / (3 * 4095);
    end
    for (int i = 0; i < n; i++) sum += s[i];
    return sum * 4079 / (n * 4095);
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_power;
    apb(1'b1, tac_pkg::OFF_CTRL, 32'h0000FFFF);
    chk(irq_out_n_oe, 1);
    apb(1'b0, tac_pkg::OFF_CTRL, 0);
    chk(q, 0);
    wait_ready;
    chk({adc_start, bias_sw}, 0);
    // the write made during power-up must not have landed
    apb(1'b0, tac_pkg::OFF_CTRL, 0);
    chk(q, 0);
  endtask
  task t_filter;
    int e;
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, tac_pkg::OFF_CTRL, 32'h7F2 | (f << 2));
      apb(1'b1, tac_pkg::OFF_CMD, f % 2);
      do begin
        apb(1'b0, tac_pkg::OFF_STATUS, 0);
      end while (q[2:1] !== 2'b10);
      apb(1'b0, tac_pkg::OFF_RESULT, 0);
      e = expv(f);
      chk(q, {19'h0, f[0], e[11:0]});
      chk({x_sel, y_sel}, 32'h3F);
    end
  endtask
  task t_pen;
    apb(1'b1, tac_pkg::OFF_CTRL, 32'hFC01);
    repeat (3) @(posedge pclk);
    chk(bias_sw, 7'h30);
    chk(det_res, 3);
    br_drop <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(irq_out_n_oe, 1);
    br_drop <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, tac_pkg::OFF_STATUS, 0);
    chk(q[0], 1);
    repeat (3) @(posedge pclk);
    chk(irq_out_n_oe, 0);
    apb(1'b0, tac_pkg::OFF_STATUS, 0);
    chk(q[0], 0);
  endtask
  task t_resets;
    apb(1'b1, tac_pkg::OFF_CTRL, 32'h40);
    apb(1'b1, tac_pkg::OFF_SOFTRST, 32'h55);
    apb(1'b0, tac_pkg::OFF_CTRL, 0);
    chk(q, 32'h40);
    apb(1'b1, tac_pkg::OFF_SOFTRST, 32'hDE);
    repeat (3) @(posedge pclk);
    chk(irq_out_n_oe, 1);
    wait_ready;
    apb(1'b0, tac_pkg::OFF_CTRL, 0);
    chk(q, 0);
    reset_in_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(irq_out_n_oe, 1);
    reset_in_n <= 1'b1;
    // two sync stages plus the power-up count keep the line low a while longer
    repeat (4) @(posedge pclk);
    chk(irq_out_n_oe, 1);
    repeat (6) @(posedge pclk);
    chk(irq_out_n_oe, 0);
    apb(1'b0, 8'h20, 0);
    chk(err, 1);
    chk(q, 0);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, br_drop, paddr, pwdata} = '0;
    reset_in_n = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_power;
    t_filter;
    t_pen;
    t_resets;
    wrap_up;
  end
endmodule
